// file: pew_pkg.sv
package pew_pkg;
	// ****************************************************************
	// Timing figures and derived cycle counts
	// ****************************************************************
	localparam int CLK_MHZ = 25;
	localparam int WRITE_TIME_MAX_US = 5000;
	localparam int BYTE_LOAD_MIN_NS = 150;
	localparam int BYTE_LOAD_MAX_US = 100;
	localparam int POST_POLL_DELAY_US = 10;
	localparam int READ_ACCESS_NS = 150;
	localparam int STROBE_WIDTH_NS = 50;
	localparam int WRITE_TIME_CYC = WRITE_TIME_MAX_US * CLK_MHZ;
	localparam int BYTE_LOAD_MIN_CYC = (BYTE_LOAD_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int BYTE_LOAD_MAX_CYC = BYTE_LOAD_MAX_US * CLK_MHZ;
	localparam int POST_POLL_CYC = POST_POLL_DELAY_US * CLK_MHZ;
	localparam int READ_ACCESS_CYC = (READ_ACCESS_NS * CLK_MHZ + 999) / 1000 + 1;
	localparam int STROBE_CYC = (STROBE_WIDTH_NS * CLK_MHZ + 999) / 1000;
	localparam int BYTE_GAP_CYC = 4;
	localparam int TOGGLE_BIT = 6;
	localparam int POLL_BIT = 7;
	localparam int PAGE_LSB = 7;

	typedef enum logic [2:0] {
		PEW_IDLE = 3'b000,
		PEW_WSTROBE = 3'b001,
		PEW_WGAP = 3'b010,
		PEW_READ = 3'b011,
		PEW_POLL = 3'b100,
		PEW_WAIT = 3'b101,
		PEW_RECOVER = 3'b110
	} pew_state_t;
endpackage

// file: pew_host.sv
// Summary of operation
// R1 - Select low, enable low, strobe high reads; select low, strobe low with enable high writes.
// R2 - The memory finishes each loaded write itself within the maximum write time.
// R3 - Without polling, wait the full maximum write time before another write.
// R4 - Page byte loads are strobe writes spaced within the byte-load interval limits.
// R5 - Upper page address bits stay fixed for all bytes of one page write; a read between loads moves the checked page to the read address.
// R6 - Enable pulses with select and strobe high between loads must not disturb the page.
// R7 - Enable low with select low between loads polls the write in progress.
// R8 - Every polling access is an ordinary read meeting read-cycle timing.
// R9 - After polling shows completion, wait the post-poll delay before writing again.
// R10 - Toggle bit alternates on successive reads while the internal write runs.
// R11 - Poll bit reads complemented until done; toggle bit then stops.
// R12 - No new load within the maximum interval ends loading and starts programming.
`timescale 1ns/1ps
`default_nettype none
module pew_host #(
	parameter int ADDR_W = 15,
	parameter int WRITE_TIME_CYC = pew_pkg::WRITE_TIME_CYC,
	parameter int POST_POLL_CYC = pew_pkg::POST_POLL_CYC,
	parameter bit USE_TOGGLE = 1'b0
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic req_write,
	input wire logic req_last,
	input wire logic [ADDR_W-1:0] req_addr,
	input wire logic [7:0] req_wdata,
	output logic rsp_valid,
	output logic [7:0] rsp_rdata,
	output logic page_error,
	output logic busy,
	output logic [ADDR_W-1:0] mem_addr,
	output logic chip_sel_n,
	output logic out_en_n,
	output logic write_n,
	input wire logic [7:0] data_in,
	output logic [7:0] data_out,
	output logic data_oe
);
	localparam int CW = 18;

	typedef struct packed {
		pew_pkg::pew_state_t st;
		logic [CW-1:0] cnt;
		logic [3:0] acc;
		logic [ADDR_W-1:0] addr;
		logic [7:0] wdata;
		logic [7:0] rdata;
		logic rsp;
		logic perr;
		logic cs_n;
		logic oe_n;
		logic we_n;
		logic doe;
		logic last;
		logic in_page;
		logic prev_tog;
		logic have_tog;
		logic [7:0] s1;
		logic [7:0] s2;
		logic [7:0] s3;
	} pew_regs_t;

	pew_regs_t q, d;

	// ****************************************************************
	// Next-state logic
	// ****************************************************************
	// The data bus passes three flops; a read samples only once stages two and three agree.
	always_comb begin
		logic done;
		logic same_page;
		same_page = req_addr[ADDR_W-1:pew_pkg::PAGE_LSB] == q.addr[ADDR_W-1:pew_pkg::PAGE_LSB];
		done = 1'b0;
		d = q;
		d.s1 = data_in;
		d.s2 = q.s1;
		d.s3 = q.s2;
		d.rsp = 1'b0;
		// The long timer keeps running through reads so the load window is not lost.
		if (q.cnt != '0) begin
			d.cnt = q.cnt - 1'b1;
		end
		// Access timer of one read or poll; every poll waits out the full access time.
		if (q.acc != '0) begin
			d.acc = q.acc - 1'b1;
		end
		unique case (q.st)
			pew_pkg::PEW_IDLE: begin
				if (req_valid && req_write && q.in_page && !same_page) begin
					// A load outside the open page would land at an unknown address.
					// A load off the page of the last load or read is dropped and flagged; the page goes on with the bytes before it.
					d.perr = 1'b1; // R5
				end else if (req_valid && req_write) begin
					d.perr = 1'b0; // R5
					d.addr = req_addr;
					d.wdata = req_wdata;
					d.last = req_last;
					d.cs_n = 1'b0; // R1
					d.oe_n = 1'b1; // R1
					d.we_n = 1'b0; // R1
					d.doe = 1'b1;
					d.cnt = CW'(pew_pkg::STROBE_CYC);
					d.st = pew_pkg::PEW_WSTROBE;
				end else if (req_valid) begin
					d.addr = req_addr;
					d.cs_n = 1'b0; // R1
					d.oe_n = 1'b0; // R8
					d.acc = 4'(pew_pkg::READ_ACCESS_CYC); // R8
					d.st = pew_pkg::PEW_READ;
				end else if (q.in_page && q.cnt == '0) begin
					// Caller stalled past the load window; the memory has begun programming.
					d.in_page = 1'b0; // R12
					d.have_tog = 1'b0;
					d.cnt = CW'(WRITE_TIME_CYC); // R3
					d.st = pew_pkg::PEW_WAIT;
				end
			end
			pew_pkg::PEW_WSTROBE: begin
				if (q.cnt == '0) begin
					d.we_n = 1'b1;
					d.cs_n = 1'b1;
					d.cnt = CW'(pew_pkg::BYTE_GAP_CYC); // R4
					d.st = pew_pkg::PEW_WGAP;
				end
			end
			pew_pkg::PEW_WGAP: begin
				if (q.cnt == '0) begin
					d.doe = 1'b0;
					if (q.last) begin
						// Ending loads lets the load window lapse so programming starts.
						d.in_page = 1'b0; // R12
						d.have_tog = 1'b0;
						d.cnt = CW'(WRITE_TIME_CYC); // R2
						d.st = pew_pkg::PEW_WAIT;
					end else begin
						d.in_page = 1'b1;
						// Next load must come before the byte-load interval runs out.
						d.cnt = CW'(pew_pkg::BYTE_LOAD_MAX_CYC - 8); // R4
						d.st = pew_pkg::PEW_IDLE;
					end
				end
			end
			pew_pkg::PEW_READ: begin
				if (q.acc == '0 && q.s2 == q.s3) begin
					d.rdata = q.s3;
					d.rsp = 1'b1;
					d.cs_n = 1'b1;
					d.oe_n = 1'b1;
					d.st = pew_pkg::PEW_IDLE;
				end
			end
			pew_pkg::PEW_WAIT: begin
				// Polls are full read cycles; a timeout covers a silent part.
				if (q.cnt == '0) begin
					d.st = pew_pkg::PEW_IDLE; // R3
				end else if (q.cs_n) begin
					d.cs_n = 1'b0; // R7
					d.oe_n = 1'b0; // R8
					d.acc = 4'(pew_pkg::READ_ACCESS_CYC); // R8
					d.st = pew_pkg::PEW_POLL;
				end
			end
			pew_pkg::PEW_POLL: begin
				// A full access must pass first, so a stale bus byte cannot end the wait.
				if (q.acc == '0 && q.s2 == q.s3) begin
					d.cs_n = 1'b1;
					d.oe_n = 1'b1;
					d.have_tog = 1'b1;
					d.prev_tog = q.s3[pew_pkg::TOGGLE_BIT];
					if (USE_TOGGLE) begin
						done = q.have_tog && (q.s3[pew_pkg::TOGGLE_BIT] == q.prev_tog); // R10
					end else begin
						done = q.s3[pew_pkg::POLL_BIT] == q.wdata[pew_pkg::POLL_BIT]; // R11
					end
					if (done) begin
						d.cnt = CW'(POST_POLL_CYC); // R9
						d.st = pew_pkg::PEW_RECOVER;
					end else begin
						d.st = pew_pkg::PEW_WAIT;
					end
				end
			end
			pew_pkg::PEW_RECOVER: begin
				if (q.cnt == '0) begin
					d.st = pew_pkg::PEW_IDLE; // R9
				end
			end
			default: begin
				d.st = pew_pkg::PEW_IDLE;
			end
		endcase
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	// Reset parks every strobe high so the memory sits in standby.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			q <= '{st: pew_pkg::PEW_IDLE, cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, default: '0};
		end else begin
			q <= d;
		end
	end

	// Outputs; a read request between loads still drives select and enable low for a full read.
	assign req_ready = q.st == pew_pkg::PEW_IDLE; // R6
	assign rsp_valid = q.rsp;
	assign rsp_rdata = q.rdata;
	assign page_error = q.perr;
	assign busy = q.st != pew_pkg::PEW_IDLE;
	assign mem_addr = q.addr;
	assign chip_sel_n = q.cs_n;
	assign out_en_n = q.oe_n;
	assign write_n = q.we_n;
	assign data_out = q.wdata;
	assign data_oe = q.doe;
endmodule
`default_nettype wire

// file: pew_properties.sv
`timescale 1ns/1ps
`default_nettype none
module pew_props (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic busy,
	input wire logic rsp_valid,
	input wire logic chip_sel_n,
	input wire logic out_en_n,
	input wire logic write_n,
	input wire logic [7:0] data_out,
	input wire logic data_oe
);
	// One clock domain, so clock and reset are given once for every check.
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence s_st; !write_n [*2]; endsequence
	sequence s_rd; (!out_en_n && !chip_sel_n) [*4]; endsequence
	property p_ws; !write_n |-> !chip_sel_n && out_en_n && data_oe; endproperty
	a_ws: assert property (p_ws) else $error("bad write");
	property p_rf; !out_en_n |-> !data_oe; endproperty
	a_rf: assert property (p_rf) else $error("bus clash");
	property p_sw; $fell(write_n) |-> s_st; endproperty
	a_sw: assert property (p_sw) else $error("short strobe");
	property p_sp; $rose(write_n) |-> write_n [*4]; endproperty
	a_sp: assert property (p_sp) else $error("loads too close");
	property p_hd; !write_n && !$fell(write_n) |-> $stable(data_out); endproperty
	a_hd: assert property (p_hd) else $error("data moved");
	property p_rd; $fell(out_en_n) |-> s_rd; endproperty
	a_rd: assert property (p_rd) else $error("short read");
	// A read ends together with its response; every poll end, finished or not, arms the write delay.
	property p_pp; $rose(out_en_n) && !rsp_valid |-> write_n [*8] ##1 write_n [*2]; endproperty
	a_pp: assert property (p_pp) else $error("early write");
	property p_bz; $rose(busy) |-> ##[1:1000] !busy; endproperty
	a_bz: assert property (p_bz) else $error("stuck busy");
endmodule
bind pew_host pew_props u_props (.sys_clk, .rst, .busy, .rsp_valid, .chip_sel_n, .out_en_n,
	.write_n, .data_out, .data_oe);
`default_nettype wire

// file: pew_mem.sv
`timescale 1ns/1ps
`default_nettype none
module pew_mem #(parameter int BUSY_CYC = 100) (
	input wire logic sys_clk,
	input wire logic [14:0] mem_addr,
	input wire logic chip_sel_n,
	input wire logic out_en_n,
	input wire logic write_n,
	input wire logic [7:0] data_out,
	output logic [7:0] data_in
);
	logic [7:0] mem [0:32767];
	logic last7_q = 1'b0, tgl_q = 1'b0, rd_q = 1'b0;
	int cnt_q = BUSY_CYC;
	wire rd = !chip_sel_n && !out_en_n && write_n;
	wire bsy = cnt_q < BUSY_CYC;
	initial data_in = 8'h00;
	// Each load restarts the quiet timer, so programming runs once loads stop.
	always @(posedge sys_clk) begin
		rd_q <= rd;
		if (rd && !rd_q) tgl_q <= !tgl_q;
		if (!chip_sel_n && !write_n && out_en_n) begin
			mem[mem_addr] <= data_out;
			last7_q <= data_out[7];
			cnt_q <= 0;
		end else if (bsy) cnt_q <= cnt_q + 1;
		data_in <= !rd ? ~data_in : bsy ? {!last7_q, tgl_q, 6'h15} : mem[mem_addr];
	end
endmodule
`default_nettype wire

// file: parallel_eeprom_write_port_test.sv
`timescale 1ns/1ps
`default_nettype none
module parallel_eeprom_write_port_test;
	logic sys_clk = 1'b0, rst = 1'b1, req_valid = 1'b0, req_write = 1'b0, req_last = 1'b0;
	logic [14:0] req_addr = 15'h0000, mem_addr, mem_addr_t;
	logic [7:0] req_wdata = 8'h00, rsp_rdata, data_in, data_out, rsp_rdata_t, data_in_t, data_out_t;
	logic req_ready, rsp_valid, page_error, busy, chip_sel_n, out_en_n, write_n, data_oe;
	logic req_ready_t, rsp_valid_t, page_error_t, busy_t, chip_sel_n_t, out_en_n_t, write_n_t;
	logic data_oe_t;
	int num_errors = 0, tests_run = 0, cyc = 0;
	// Short write and recovery counts keep the run brief.
	pew_host #(.WRITE_TIME_CYC(200), .POST_POLL_CYC(10)) u_dut (.sys_clk, .rst, .req_valid,
		.req_ready, .req_write, .req_last, .req_addr, .req_wdata, .rsp_valid, .rsp_rdata,
		.page_error, .busy, .mem_addr, .chip_sel_n, .out_en_n, .write_n, .data_in, .data_out, .data_oe);
	pew_mem u_mem (.sys_clk, .mem_addr, .chip_sel_n, .out_en_n, .write_n, .data_out, .data_in);
	// A second controller polls the toggle bit; both see the same requests in lockstep.
	pew_host #(.WRITE_TIME_CYC(200), .POST_POLL_CYC(10), .USE_TOGGLE(1'b1)) u_dut_tgl (
		.sys_clk, .rst, .req_valid, .req_ready(req_ready_t), .req_write, .req_last, .req_addr,
		.req_wdata, .rsp_valid(rsp_valid_t), .rsp_rdata(rsp_rdata_t), .page_error(page_error_t),
		.busy(busy_t), .mem_addr(mem_addr_t), .chip_sel_n(chip_sel_n_t), .out_en_n(out_en_n_t),
		.write_n(write_n_t), .data_in(data_in_t), .data_out(data_out_t), .data_oe(data_oe_t));
	pew_mem u_mem_tgl (.sys_clk, .mem_addr(mem_addr_t), .chip_sel_n(chip_sel_n_t),
		.out_en_n(out_en_n_t), .write_n(write_n_t), .data_out(data_out_t), .data_in(data_in_t));
	// Free running clock.
	initial forever #20 sys_clk = ~sys_clk;
	// A hang counts as a mismatch and ends the run.
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) num_errors = num_errors + 1;
		if (cyc == 20000) report_and_stop();
	end
	task automatic chk(string n, logic [7:0] e, logic [7:0] g);
		tests_run++;
		if (g !== e) num_errors++;
		if (g !== e) $display("[ERR] %s exp %h got %h", n, e, g);
	endtask
	task automatic req(logic w, logic l, logic [14:0] a, logic [7:0] d);
		int k = 0;
		@(negedge sys_clk);
		{req_valid, req_write, req_last, req_addr, req_wdata} = {1'b1, w, l, a, d};
		// Ready is judged at the falling edge where it has settled; the next rising edge takes it.
		while ((req_ready !== 1'b1 || req_ready_t !== 1'b1) && k < 3000) begin
			@(negedge sys_clk);
			k++;
		end
		@(posedge sys_clk);
		@(negedge sys_clk);
		req_valid = 1'b0;
	endtask
	task automatic rd(logic [14:0] a, logic [7:0] e);
		int k = 0;
		req(1'b0, 1'b1, a, 8'h00);
		while (rsp_valid !== 1'b1 && k < 99) begin
			@(negedge sys_clk);
			k++;
		end
		chk("rsp_valid", 8'h01, {7'h00, rsp_valid});
		chk("rsp_valid_tgl", 8'h01, {7'h00, rsp_valid_t});
		chk("rdata", e, rsp_rdata);
		chk("rdata_tgl", e, rsp_rdata_t);
	endtask
	task automatic idle();
		int k = 0;
		do @(negedge sys_clk); while ((busy !== 1'b0 || busy_t !== 1'b0) && ++k < 2000);
	endtask
	task automatic t_single();
		req(1'b1, 1'b1, 15'h0105, 8'h5a);
		idle();
		rd(15'h0105, 8'h5a);
		repeat (10) @(negedge sys_clk);
		$display("single write done");
	endtask
	task automatic t_page();
		req(1'b1, 1'b0, 15'h0280, 8'h11);
		req(1'b1, 1'b0, 15'h0281, 8'h22);
		// A load outside the open page must be refused and flagged.
		req(1'b1, 1'b0, 15'h0105, 8'hee);
		chk("page_err", 8'h01, {7'h00, page_error});
		chk("page_err_tgl", 8'h01, {7'h00, page_error_t});
		req(1'b1, 1'b1, 15'h02ff, 8'h83);
		idle();
		chk("page", 8'h00, {7'h00, page_error});
		rd(15'h0281, 8'h22);
		rd(15'h02ff, 8'h83);
		rd(15'h0105, 8'h5a);
		$display("page write done");
	endtask
	task automatic report_and_stop();
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// Reset for 20 cycles, then the scenarios in turn.
	initial begin
		repeat (20) @(negedge sys_clk);
		rst = 1'b0;
		t_single();
		t_page();
		report_and_stop();
	end
endmodule
`default_nettype wire
